// [inc/i2c_evt_pkg.sv]
// Shared constants for the I2C event status flag block
package i2c_evt_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam logic [7:0]  OFF_FLAGS   = 8'h08;
    localparam logic [7:0]  OFF_ENABLE  = 8'h0c;
    localparam logic [7:0]  OFF_THRESH  = 8'h10;

    // ****************************************
    // Flag field positions
    // ****************************************
    localparam int unsigned FLAG_W      = 9;
    localparam int unsigned BIT_DONE    = 0;
    localparam int unsigned BIT_IRXM    = 1;
    localparam int unsigned BIT_GCALL   = 2;
    localparam int unsigned BIT_AMATCH  = 3;
    localparam int unsigned BIT_RXTH    = 4;
    localparam int unsigned BIT_TXTH    = 5;
    localparam int unsigned BIT_STOP    = 6;
    localparam int unsigned BIT_ADRACK  = 7;
    localparam int unsigned BIT_ARBLOST = 8;

    // Bits held until written with a one; the rest follow FIFO levels
    localparam logic [8:0]  STICKY_MASK = 9'h1cf;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [8:0]  FLAGS_RST   = 9'h030;
    localparam logic [8:0]  ENABLE_RST  = 9'h000;

    // ****************************************
    // Threshold register layout
    // ****************************************
    localparam int unsigned CNT_W       = 4;
    localparam int unsigned TXTH_LSB    = 0;
    localparam int unsigned RXTH_LSB    = 8;
    localparam logic [3:0]  TXTH_RST    = 4'h0;
    localparam logic [3:0]  RXTH_RST    = 4'h0;

endpackage

// [hw/w1c_flag_cell.sv]
// One sticky event flag, set by hardware and cleared by a software write of one
`timescale 1ns/1ns
module w1c_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic set_evt,
    input  wire logic clr_req,
    output logic      flag_r
);

    // Set has priority so an event in the clearing cycle is kept
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flag_r <= RST_VAL;
        end else if (set_evt) begin
            flag_r <= 1'b1;
        end else if (clr_req) begin
            flag_r <= 1'b0;
        end
    end

endmodule

// [hw/i2c_event_flags.sv]
// I2C event status flags, enables and interrupt request for the low nine events
//
// Operation
// RULE_01 - Arbitration loss as master sets bit 8
// RULE_02 - Address acknowledged as master sets bit 7
// RULE_03 - STOP seen as slave sets bit 6
// RULE_04 - Bit 5 high when TX count within threshold
// RULE_05 - Bit 5 low when TX count exceeds threshold
// RULE_06 - Bit 4 high when RX count reaches threshold
// RULE_07 - Bit 4 low when RX count below threshold
// RULE_08 - Reset: threshold flags one, others zero
// RULE_09 - Own address match as slave sets bit 3
// RULE_10 - General call match as slave sets bit 2
// RULE_11 - Interactive receive event sets bit 1
// RULE_12 - Transfer complete after acknowledge sets bit 0
// RULE_13 - Writing one clears, writing zero keeps
// RULE_14 - Each flag has same-position enable bit
// RULE_15 - Interrupt high while enabled flag set
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module i2c_event_flags #(
    parameter int unsigned CNT_W = i2c_evt_pkg::CNT_W
) (
    input  wire logic                             clk_sys,
    input  wire logic                             reset,
    input  wire logic [i2c_evt_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [i2c_evt_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic      [i2c_evt_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic                             master_mode,
    input  wire logic                             arb_lost_evt,
    input  wire logic                             addr_ack_evt,
    input  wire logic                             stop_evt,
    input  wire logic                             addr_match_evt,
    input  wire logic                             gen_call_evt,
    input  wire logic                             irx_evt,
    input  wire logic                             done_evt,
    input  wire logic [CNT_W-1:0]                 tx_count,
    input  wire logic [CNT_W-1:0]                 rx_count,
    output logic                                  irq
);
    import i2c_evt_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    wire  [FLAG_W-1:0]  flags;
    logic [FLAG_W-1:0]  evt_vec;
    logic [FLAG_W-1:0]  clr_vec;
    logic [FLAG_W-1:0]  enable_r;
    logic [CNT_W-1:0]   tx_thresh_r;
    logic [CNT_W-1:0]   rx_thresh_r;
    logic               txth_r;
    logic               rxth_r;
    logic [DATA_W-1:0]  rdata_r;
    logic               wr_flags;
    logic               wr_enable;
    logic               wr_thresh;
    logic               after_rst_r;

    // ****************************************
    // Register decode
    // ****************************************
    assign wr_flags  = reg_wr && (reg_addr == OFF_FLAGS);
    assign wr_enable = reg_wr && (reg_addr == OFF_ENABLE);
    assign wr_thresh = reg_wr && (reg_addr == OFF_THRESH);

    // ****************************************
    // Event qualification by role
    // ****************************************
    always_comb begin
        evt_vec              = '0;
        evt_vec[BIT_ARBLOST] = arb_lost_evt && master_mode;    // RULE_01
        evt_vec[BIT_ADRACK]  = addr_ack_evt && master_mode;    // RULE_02
        evt_vec[BIT_STOP]    = stop_evt && !master_mode;       // RULE_03
        evt_vec[BIT_AMATCH]  = addr_match_evt && !master_mode; // RULE_09
        evt_vec[BIT_GCALL]   = gen_call_evt && !master_mode;   // RULE_10
        evt_vec[BIT_IRXM]    = irx_evt;                        // RULE_11
        evt_vec[BIT_DONE]    = done_evt;                       // RULE_12
    end

    // Only ones written to sticky positions clear anything
    always_comb begin
        clr_vec = '0;
        if (wr_flags) begin
            clr_vec = reg_wdata[FLAG_W-1:0] & STICKY_MASK; // RULE_13
        end
    end

    // ****************************************
    // Flag storage
    // ****************************************
    for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
        if (STICKY_MASK[i]) begin : g_sticky
            w1c_flag_cell #(
                .RST_VAL (FLAGS_RST[i])
            ) u_cell (
                .clk_sys (clk_sys),
                .reset   (reset),
                .set_evt (evt_vec[i]),
                .clr_req (clr_vec[i]),
                .flag_r  (flags[i])
            );
        end else begin : g_level
            assign flags[i] = (i == BIT_TXTH) ? txth_r : rxth_r;
        end
    end

    // ****************************************
    // FIFO threshold levels
    // ****************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            txth_r <= FLAGS_RST[BIT_TXTH]; // RULE_08
            rxth_r <= FLAGS_RST[BIT_RXTH]; // RULE_08
        end else begin
            txth_r <= (tx_count <= tx_thresh_r); // RULE_04 RULE_05
            rxth_r <= (rx_count >= rx_thresh_r); // RULE_06 RULE_07
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_thresh_r <= CNT_W'(TXTH_RST);
            rx_thresh_r <= CNT_W'(RXTH_RST);
        end else if (wr_thresh) begin
            tx_thresh_r <= reg_wdata[TXTH_LSB +: CNT_W];
            rx_thresh_r <= reg_wdata[RXTH_LSB +: CNT_W];
        end
    end

    // ****************************************
    // Enable register
    // ****************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable_r <= ENABLE_RST;
        end else if (wr_enable) begin
            enable_r <= reg_wdata[FLAG_W-1:0]; // RULE_14
        end
    end

    // ****************************************
    // Interrupt request
    // ****************************************
    assign irq = |(flags & enable_r); // RULE_14 RULE_15

    // ****************************************
    // Read port
    // ****************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_FLAGS: begin
                    rdata_r <= {{(DATA_W-FLAG_W){1'b0}}, flags};
                end
                OFF_ENABLE: begin
                    rdata_r <= {{(DATA_W-FLAG_W){1'b0}}, enable_r};
                end
                OFF_THRESH: begin
                    rdata_r <= '0;
                    rdata_r[TXTH_LSB +: CNT_W] <= tx_thresh_r;
                    rdata_r[RXTH_LSB +: CNT_W] <= rx_thresh_r;
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata = rdata_r;

    // ****************************************
    // Checks
    // ****************************************
    // Marks the first clock edge after reset release
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            after_rst_r <= 1'b1;
        end else begin
            after_rst_r <= 1'b0;
        end
    end

    property p_arb_set;
        @(posedge clk_sys) disable iff (reset)
        (arb_lost_evt && master_mode) |=> flags[BIT_ARBLOST];
    endproperty
    a_arb_set: assert property (p_arb_set) else $error("arbitration flag not set"); // RULE_01

    property p_arb_clear;
        @(posedge clk_sys) disable iff (reset)
        (wr_flags && reg_wdata[BIT_ARBLOST] && !(arb_lost_evt && master_mode))
            |=> !flags[BIT_ARBLOST];
    endproperty
    a_arb_clear: assert property (p_arb_clear) else $error("arbitration flag not cleared"); // RULE_01

    property p_adrack_set;
        @(posedge clk_sys) disable iff (reset)
        (addr_ack_evt && master_mode) |=> flags[BIT_ADRACK] [*1];
    endproperty
    a_adrack_set: assert property (p_adrack_set) else $error("address ack flag not set"); // RULE_02

    property p_stop_set;
        @(posedge clk_sys) disable iff (reset)
        (stop_evt && !master_mode) |=> flags[BIT_STOP];
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop flag not set"); // RULE_03

    property p_txth_high;
        @(posedge clk_sys) disable iff (reset)
        (tx_count <= tx_thresh_r) |=> flags[BIT_TXTH];
    endproperty
    a_txth_high: assert property (p_txth_high) else $error("tx threshold flag low"); // RULE_04

    property p_txth_low;
        @(posedge clk_sys) disable iff (reset)
        (tx_count > tx_thresh_r) |=> !flags[BIT_TXTH];
    endproperty
    a_txth_low: assert property (p_txth_low) else $error("tx threshold flag high"); // RULE_05

    property p_rxth_high;
        @(posedge clk_sys) disable iff (reset)
        (rx_count >= rx_thresh_r) |=> flags[BIT_RXTH];
    endproperty
    a_rxth_high: assert property (p_rxth_high) else $error("rx threshold flag low"); // RULE_06

    property p_rxth_low;
        @(posedge clk_sys) disable iff (reset)
        (rx_count < rx_thresh_r) |=> !flags[BIT_RXTH];
    endproperty
    a_rxth_low: assert property (p_rxth_low) else $error("rx threshold flag high"); // RULE_07

    property p_reset_vals;
        @(posedge clk_sys) disable iff (reset)
        after_rst_r |-> (flags == FLAGS_RST) && (enable_r == ENABLE_RST) && !irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong flag values after reset"); // RULE_08

    property p_amatch_set;
        @(posedge clk_sys) disable iff (reset)
        (addr_match_evt && !master_mode) |=> flags[BIT_AMATCH];
    endproperty
    a_amatch_set: assert property (p_amatch_set) else $error("address match flag not set"); // RULE_09

    property p_gcall_set;
        @(posedge clk_sys) disable iff (reset)
        (gen_call_evt && !master_mode) |=> flags[BIT_GCALL];
    endproperty
    a_gcall_set: assert property (p_gcall_set) else $error("general call flag not set"); // RULE_10

    property p_irx_keep;
        @(posedge clk_sys) disable iff (reset)
        (flags[BIT_IRXM] && wr_flags && !reg_wdata[BIT_IRXM]) |=> flags[BIT_IRXM];
    endproperty
    a_irx_keep: assert property (p_irx_keep) else $error("interactive flag lost on zero write"); // RULE_11

    property p_done_set;
        @(posedge clk_sys) disable iff (reset)
        done_evt ##1 (wr_flags && reg_wdata[BIT_DONE] && !done_evt) |-> flags[BIT_DONE] ##1 !flags[BIT_DONE];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag set or clear wrong"); // RULE_12

    property p_sticky_hold;
        @(posedge clk_sys) disable iff (reset)
        (!wr_flags && ((evt_vec & STICKY_MASK) == '0))
            |=> ((flags & STICKY_MASK) == ($past(flags) & STICKY_MASK));
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag changed untouched"); // RULE_13

    property p_irq_low;
        @(posedge clk_sys) disable iff (reset)
        (wr_enable && reg_wdata[FLAG_W-1:0] == '0) |=> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt without enabled flag"); // RULE_14

    property p_irq_follow;
        @(posedge clk_sys) disable iff (reset)
        (wr_enable && (reg_wdata[FLAG_W-1:0] & flags & STICKY_MASK) != '0 && !wr_flags) |=> irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("interrupt missing for enabled flag"); // RULE_15

    property p_read_flags;
        @(posedge clk_sys) disable iff (reset)
        (reg_rd && reg_addr == OFF_FLAGS) |=> (reg_rdata[FLAG_W-1:0] == $past(flags))
            ##1 ($past(reg_rd) || reg_rdata == '0);
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("flag read data wrong"); // RULE_13

    property p_arb_role;
        @(posedge clk_sys) disable iff (reset)
        (!master_mode && !flags[BIT_ARBLOST]) |=> !flags[BIT_ARBLOST];
    endproperty
    a_arb_role: assert property (p_arb_role) else $error("arbitration flag set in slave role"); // RULE_01

    property p_adrack_role;
        @(posedge clk_sys) disable iff (reset)
        (!master_mode && !flags[BIT_ADRACK]) |=> !flags[BIT_ADRACK];
    endproperty
    a_adrack_role: assert property (p_adrack_role) else $error("address ack flag set in slave role"); // RULE_02

    property p_stop_role;
        @(posedge clk_sys) disable iff (reset)
        (master_mode && !flags[BIT_STOP]) |=> !flags[BIT_STOP];
    endproperty
    a_stop_role: assert property (p_stop_role) else $error("stop flag set in master role"); // RULE_03

    property p_amatch_role;
        @(posedge clk_sys) disable iff (reset)
        (master_mode && !flags[BIT_AMATCH]) |=> !flags[BIT_AMATCH];
    endproperty
    a_amatch_role: assert property (p_amatch_role) else $error("address match flag set in master role"); // RULE_09

    property p_gcall_role;
        @(posedge clk_sys) disable iff (reset)
        (master_mode && !flags[BIT_GCALL]) |=> !flags[BIT_GCALL];
    endproperty
    a_gcall_role: assert property (p_gcall_role) else $error("general call flag set in master role"); // RULE_10

    property p_irx_set;
        @(posedge clk_sys) disable iff (reset)
        irx_evt |=> flags[BIT_IRXM];
    endproperty
    a_irx_set: assert property (p_irx_set) else $error("interactive flag not set"); // RULE_11

    property p_done_any;
        @(posedge clk_sys) disable iff (reset)
        done_evt |=> flags[BIT_DONE];
    endproperty
    a_done_any: assert property (p_done_any) else $error("done flag not set"); // RULE_12

    property p_set_wins;
        @(posedge clk_sys) disable iff (reset)
        ((evt_vec & clr_vec) != '0) |=> ((flags & $past(evt_vec)) == $past(evt_vec));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat event in same cycle"); // RULE_13

    property p_enable_wr;
        @(posedge clk_sys) disable iff (reset)
        wr_enable |=> (enable_r == $past(reg_wdata[FLAG_W-1:0]));
    endproperty
    a_enable_wr: assert property (p_enable_wr) else $error("enable register write lost"); // RULE_14

endmodule

// [tb/i2c_bus_agent.sv]
// Behavioural bus agents that raise the protocol events seen by the flag block
`timescale 1ns/1ns
module i2c_bus_agent (
    input  wire logic       clk_sys,
    input  wire logic       fire,
    input  wire logic [2:0] sel,
    output logic            arb_lost_evt,
    output logic            addr_ack_evt,
    output logic            stop_evt,
    output logic            addr_match_evt,
    output logic            gen_call_evt,
    output logic            irx_evt,
    output logic            done_evt
);
    // ****************************************
    // Event pulses
    // ****************************************
    // One-cycle pulse on the chosen line, launched just after the edge
    always_ff @(posedge clk_sys) begin
        arb_lost_evt   <= fire && sel == 3'h0;
        addr_ack_evt   <= fire && sel == 3'h1;
        stop_evt       <= fire && sel == 3'h2;
        addr_match_evt <= fire && sel == 3'h3;
        gen_call_evt   <= fire && sel == 3'h4;
        irx_evt        <= fire && sel == 3'h5;
        done_evt       <= fire && sel == 3'h6;
    end
endmodule

// [tb/tb.sv]
// Self-checking bench for the I2C event status flag block
`timescale 1ns/1ns
module tb;
    import i2c_evt_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        master_mode = 1'b0;
    logic        fire = 1'b0;
    logic [2:0]  sel = 3'h0;
    logic        arb_lost_evt, addr_ack_evt, stop_evt, addr_match_evt, gen_call_evt, irx_evt, done_evt;
    logic [3:0]  tx_count = 4'h0;
    logic [3:0]  rx_count = 4'h0;
    logic        irq;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          pos [7] = '{8, 7, 6, 3, 2, 1, 0};
    logic        role [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    always #5 clk_sys = ~clk_sys;

    i2c_event_flags i2c_event_flags_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .master_mode(master_mode), .arb_lost_evt(arb_lost_evt), .addr_ack_evt(addr_ack_evt),
        .stop_evt(stop_evt), .addr_match_evt(addr_match_evt), .gen_call_evt(gen_call_evt),
        .irx_evt(irx_evt), .done_evt(done_evt), .tx_count(tx_count), .rx_count(rx_count), .irq(irq));

    i2c_bus_agent i2c_bus_agent_inst (.clk_sys(clk_sys), .fire(fire), .sel(sel),
        .arb_lost_evt(arb_lost_evt), .addr_ack_evt(addr_ack_evt), .stop_evt(stop_evt),
        .addr_match_evt(addr_match_evt), .gen_call_evt(gen_call_evt), .irx_evt(irx_evt),
        .done_evt(done_evt));

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        chk(what, reg_rdata, exp);
        @(posedge clk_sys);
    endtask

    task automatic ichk(input logic exp);
        @(negedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, exp});
        @(posedge clk_sys);
    endtask

    // Event pulse from the agent, taken by the block at the second edge
    task automatic pulse(input logic [2:0] s);
        fire <= 1'b1;
        sel  <= s;
        @(posedge clk_sys);
        fire <= 1'b0;
        @(posedge clk_sys);
    endtask

    // ****************************************
    // Hang guard
    // ****************************************
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rchk("flags", OFF_FLAGS, 32'h030);
        rchk("enable", OFF_ENABLE, 32'h0);
        wr(OFF_ENABLE, 32'hffffffff);
        rchk("enable", OFF_ENABLE, 32'h1ff);
        wr(8'h20, 32'hffffffff);
        rchk("unmapped", 8'h20, 32'h0);
        wr(OFF_ENABLE, 32'h1cf);
        for (int i = 0; i < 7; i++) begin
            master_mode <= role[i];
            pulse(3'(i));
            rchk("flag set", OFF_FLAGS, 32'h030 | (32'h1 << pos[i]));
            ichk(1'b1);
            wr(OFF_FLAGS, 32'h0);
            rchk("flag kept", OFF_FLAGS, 32'h030 | (32'h1 << pos[i]));
            wr(OFF_FLAGS, 32'h1 << pos[i]);
            rchk("flag clear", OFF_FLAGS, 32'h030);
            ichk(1'b0);
        end
        // Events seen in the wrong role leave the flags alone
        for (int i = 0; i < 5; i++) begin
            master_mode <= ~role[i];
            pulse(3'(i));
            rchk("wrong role", OFF_FLAGS, 32'h030);
        end
        pulse(3'h6);
        rchk("done master", OFF_FLAGS, 32'h031);
        wr(OFF_ENABLE, 32'h0);
        ichk(1'b0);
        wr(OFF_ENABLE, 32'h1);
        ichk(1'b1);
        // Event and clear of the same bit in one cycle
        fire      <= 1'b1;
        sel       <= 3'h5;
        @(posedge clk_sys);
        fire      <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= OFF_FLAGS;
        reg_wdata <= 32'h2;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
        rchk("set wins", OFF_FLAGS, 32'h033);
        wr(OFF_FLAGS, 32'h3);
        rchk("both clear", OFF_FLAGS, 32'h030);
        // Done event followed at once by its clear
        pulse(3'h6);
        wr(OFF_FLAGS, 32'h1);
        rchk("done clear", OFF_FLAGS, 32'h030);
        // FIFO level flags against thresholds of 3 and 5
        wr(OFF_THRESH, 32'h0503);
        rchk("thresh", OFF_THRESH, 32'h0503);
        wr(OFF_ENABLE, 32'h020);
        for (int c = 0; c < 16; c++) begin
            tx_count <= 4'(c);
            rx_count <= 4'(c);
            repeat (2) @(posedge clk_sys);
            wr(OFF_FLAGS, 32'h030);
            rchk("levels", OFF_FLAGS, {26'h0, c <= 3, c >= 5, 4'h0});
            ichk(c <= 3);
        end
        // Reset in mid-run with a sticky flag pending
        pulse(3'h5);
        reset    <= 1'b1;
        tx_count <= 4'h0;
        rx_count <= 4'h0;
        @(posedge clk_sys);
        reset    <= 1'b0;
        @(posedge clk_sys);
        rchk("flags", OFF_FLAGS, 32'h030);
        rchk("thresh", OFF_THRESH, 32'h0);
        stop_test();
    end
endmodule
